// File: core/irq_ctl_pkg.sv
// Constants, command codes and state encodings for the interrupt mask and trigger logic
package irq_ctl_pkg;
    localparam int          LEVELS            = 8;
    localparam int          LEVEL_W           = 3;
    // Reset and initialization values
    localparam logic [7:0]  MASK_RESET        = 8'h00;
    localparam logic [7:0]  SERVICE_RESET     = 8'h00;
    localparam logic [7:0]  LATCH_RESET       = 8'h00;
    localparam logic [7:0]  ARMED_RESET       = 8'hff;
    localparam logic [2:0]  LOWEST_RESET      = 3'h7;
    localparam logic [2:0]  LEVEL_SEVEN       = 3'h7;
    localparam logic        LEVEL_MODE_RESET  = 1'b0;
    localparam logic        AUTO_EOS_RESET    = 1'b0;
    // Operation command codes on cmd_code
    localparam logic [2:0]  CMD_NONSPEC_EOS   = 3'h1;
    localparam logic [2:0]  CMD_SPEC_EOS      = 3'h3;
    localparam logic [2:0]  CMD_NONSPEC_ROT   = 3'h5;
    localparam logic [2:0]  CMD_SPEC_ROT      = 3'h7;
    localparam logic [2:0]  CMD_SET_PRIORITY  = 3'h6;
    localparam logic [2:0]  CMD_SPMASK_SET    = 3'h2;
    localparam logic [2:0]  CMD_SPMASK_CLEAR  = 3'h4;

    typedef logic [LEVEL_W-1:0] level_t;

    // Acknowledge sequence, one-hot
    typedef enum logic [3:0] {
        ACK_IDLE   = 4'h1,
        ACK_FIRST  = 4'h2,
        ACK_GAP    = 4'h4,
        ACK_SECOND = 4'h8
    } ack_state_t;
endpackage : irq_ctl_pkg

// File: core/priority_pick.sv
// Rotating priority picker: finds the highest-priority set bit of a level vector
`timescale 1ns/100ps
module priority_pick (
    // Levels to choose from
    input  wire logic [irq_ctl_pkg::LEVELS-1:0] candidates,
    input  wire logic [irq_ctl_pkg::LEVEL_W-1:0] lowest_level,
    // Result
    output logic                                 found,
    output logic [irq_ctl_pkg::LEVEL_W-1:0]      level,
    output logic [irq_ctl_pkg::LEVEL_W-1:0]      rank
);
    import irq_ctl_pkg::*;

    // Rank 0 is the level just after the lowest one
    function automatic level_t level_at_rank(input level_t low, input level_t r);
        level_at_rank = low + 3'h1 + r;
    endfunction : level_at_rank

    always_comb
    begin
        found = 1'b0;
        level = 3'h0;
        rank  = 3'h0;
        // Scan from lowest priority so the last hit is the winner
        for (int i = LEVELS - 1; i >= 0; i--)
        begin
            if (candidates[level_at_rank(lowest_level, 3'(i))])
            begin
                found = 1'b1;
                level = level_at_rank(lowest_level, 3'(i));
                rank  = 3'(i);
            end
        end
    end
endmodule : priority_pick

// File: core/interrupt_mask_trigger_logic.sv
// Eight-level priority interrupt controller: masking, rotation, special mask, trigger modes
`timescale 1ns/100ps
module interrupt_mask_trigger_logic (
    // Clock and reset
    input  wire logic                                 sys_clk,
    input  wire logic                                 rstn,
    // Peripheral request lines, active low
    input  wire logic [irq_ctl_pkg::LEVELS-1:0]       bus_vectored_request_lines_n,
    // Initialization
    input  wire logic                                 init_valid,
    input  wire logic                                 init_level_mode,
    input  wire logic                                 init_auto_eos,
    // Mask write
    input  wire logic                                 mask_write,
    input  wire logic [irq_ctl_pkg::LEVELS-1:0]       mask_data,
    // Operation commands
    input  wire logic                                 cmd_valid,
    input  wire logic [2:0]                           cmd_code,
    input  wire logic [irq_ctl_pkg::LEVEL_W-1:0]      cmd_level,
    // Acknowledge from the processor, active high
    input  wire logic                                 acknowledge_pulse,
    // Interrupt and acknowledge answer
    output logic                                      int_request,
    output logic [irq_ctl_pkg::LEVEL_W-1:0]           ack_level,
    output logic                                      ack_default,
    // State for read-back
    output logic [irq_ctl_pkg::LEVELS-1:0]            level_mask_bits,
    output logic [irq_ctl_pkg::LEVELS-1:0]            in_service_bits,
    output logic [irq_ctl_pkg::LEVELS-1:0]            request_latch_bits,
    output logic                                      special_mask_setting,
    output logic                                      level_mode,
    output logic [irq_ctl_pkg::LEVEL_W-1:0]           lowest_level
);
    import irq_ctl_pkg::*;

    // Request synchronizer and edge sample
    logic [LEVELS-1:0] req_meta;
    logic [LEVELS-1:0] req_sync;
    logic [LEVELS-1:0] req_prev;
    logic              ack_prev;

    // Request sensing state
    logic [LEVELS-1:0] armed;
    logic [LEVELS-1:0] next_armed;
    logic [LEVELS-1:0] next_request_latch_bits;

    // Control state
    ack_state_t        ack_state;
    ack_state_t        next_ack_state;
    logic [LEVELS-1:0] next_level_mask_bits;
    logic [LEVELS-1:0] next_in_service_bits;
    logic              next_special_mask_setting;
    logic              next_level_mode;
    logic              auto_eos;
    logic              next_auto_eos;
    level_t            next_lowest_level;
    logic              next_int_request;
    level_t            next_ack_level;
    logic              next_ack_default;
    logic              served_valid;
    logic              next_served_valid;
    level_t            served_level;
    level_t            next_served_level;

    // Priority resolution
    logic [LEVELS-1:0] req_candidates;
    logic [LEVELS-1:0] svc_candidates;
    logic              req_found;
    level_t            req_level;
    level_t            req_rank;
    logic              svc_found;
    level_t            svc_level;
    level_t            svc_rank;
    logic              raise;
    logic              ack_rise;
    logic              ack_fall;
    logic              capture;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            req_meta <= LATCH_RESET;
            req_sync <= LATCH_RESET;
            req_prev <= LATCH_RESET;
            ack_prev <= 1'b0;
        end
        else
        begin
            req_meta <= ~bus_vectored_request_lines_n;
            req_sync <= req_meta;
            req_prev <= req_sync;
            ack_prev <= acknowledge_pulse;
        end
    end

    // Masking acts after the latch, never before it
    assign req_candidates = request_latch_bits & ~level_mask_bits;
    // Masked in-service bits vanish while special mask is on
    assign svc_candidates = special_mask_setting ?
                            (in_service_bits & ~level_mask_bits) : in_service_bits;

    priority_pick req_pick (
        .candidates   (req_candidates),
        .lowest_level (lowest_level),
        .found        (req_found),
        .level        (req_level),
        .rank         (req_rank)
    );

    priority_pick svc_pick (
        .candidates   (svc_candidates),
        .lowest_level (lowest_level),
        .found        (svc_found),
        .level        (svc_level),
        .rank         (svc_rank)
    );

    // Nested blocking unless special mask mode is on
    assign raise = req_found &&
                   (special_mask_setting || !svc_found || (req_rank < svc_rank));

    assign ack_rise = acknowledge_pulse && !ack_prev;
    assign ack_fall = !acknowledge_pulse && ack_prev;
    assign capture  = (ack_state == ACK_IDLE) && ack_rise;

    // Request latch and edge lockout
    always_comb
    begin
        next_armed              = armed;
        next_request_latch_bits = request_latch_bits;
        for (int i = 0; i < LEVELS; i++)
        begin
            if (level_mode)
            begin
                next_armed[i]              = 1'b1;
                next_request_latch_bits[i] = req_sync[i];
            end
            else
            begin
                // A latched request that drops before acknowledge is lost
                next_request_latch_bits[i] = (request_latch_bits[i] && req_sync[i]) ||
                                             (req_sync[i] && !req_prev[i] && armed[i]);
                if (!req_sync[i])
                begin
                    next_armed[i] = 1'b1;
                end
                if (capture && req_found && (req_level == 3'(i)))
                begin
                    next_armed[i]              = 1'b0;
                    next_request_latch_bits[i] = 1'b0;
                end
            end
        end
        if (init_valid)
        begin
            next_armed              = ARMED_RESET;
            next_request_latch_bits = LATCH_RESET;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            armed              <= ARMED_RESET;
            request_latch_bits <= LATCH_RESET;
        end
        else
        begin
            armed              <= next_armed;
            request_latch_bits <= next_request_latch_bits;
        end
    end

    // Commands, mask, in-service bits and acknowledge sequence
    always_comb
    begin
        next_level_mask_bits      = level_mask_bits;
        next_in_service_bits      = in_service_bits;
        next_special_mask_setting = special_mask_setting;
        next_level_mode           = level_mode;
        next_auto_eos             = auto_eos;
        next_lowest_level         = lowest_level;
        next_ack_state            = ack_state;
        next_ack_level            = ack_level;
        next_ack_default          = ack_default;
        next_served_valid         = served_valid;
        next_served_level         = served_level;

        if (mask_write)
        begin
            next_level_mask_bits = mask_data;
        end

        if (cmd_valid)
        begin
            case (cmd_code)
                CMD_NONSPEC_EOS:
                begin
                    if (svc_found)
                    begin
                        next_in_service_bits[svc_level] = 1'b0;
                    end
                end
                CMD_NONSPEC_ROT:
                begin
                    if (svc_found)
                    begin
                        next_in_service_bits[svc_level] = 1'b0;
                        next_lowest_level               = svc_level;
                    end
                end
                CMD_SPEC_EOS:
                begin
                    next_in_service_bits[cmd_level] = 1'b0;
                end
                CMD_SPEC_ROT:
                begin
                    // Clear and rotate in the same edge
                    next_in_service_bits[cmd_level] = 1'b0;
                    next_lowest_level               = cmd_level;
                end
                CMD_SET_PRIORITY:
                begin
                    next_lowest_level = cmd_level;
                end
                CMD_SPMASK_SET:
                begin
                    next_special_mask_setting = 1'b1;
                end
                CMD_SPMASK_CLEAR:
                begin
                    next_special_mask_setting = 1'b0;
                end
                default:
                begin
                    next_special_mask_setting = special_mask_setting;
                end
            endcase
        end

        case (ack_state)
            ACK_IDLE:
            begin
                if (ack_rise)
                begin
                    next_ack_state = ACK_FIRST;
                    if (req_found)
                    begin
                        next_in_service_bits[req_level] = 1'b1;
                        next_ack_level                  = req_level;
                        next_ack_default                = 1'b0;
                        next_served_valid               = 1'b1;
                        next_served_level               = req_level;
                    end
                    else
                    begin
                        // Source let go too early: spurious answer, nothing in service
                        next_ack_level    = LEVEL_SEVEN;
                        next_ack_default  = 1'b1;
                        next_served_valid = 1'b0;
                    end
                end
            end
            ACK_FIRST:
            begin
                if (ack_fall)
                begin
                    next_ack_state = ACK_GAP;
                end
            end
            ACK_GAP:
            begin
                if (ack_rise)
                begin
                    next_ack_state = ACK_SECOND;
                end
            end
            ACK_SECOND:
            begin
                if (ack_fall)
                begin
                    next_ack_state = ACK_IDLE;
                    if (auto_eos && served_valid)
                    begin
                        next_in_service_bits[served_level] = 1'b0;
                    end
                end
            end
            default:
            begin
                next_ack_state = ACK_IDLE;
            end
        endcase

        // Re-initialization restores the documented defaults
        if (init_valid)
        begin
            next_level_mode           = init_level_mode;
            next_auto_eos             = init_auto_eos;
            next_level_mask_bits      = MASK_RESET;
            next_in_service_bits      = SERVICE_RESET;
            next_special_mask_setting = 1'b0;
            next_lowest_level         = LOWEST_RESET;
            next_ack_state            = ACK_IDLE;
            next_served_valid         = 1'b0;
        end

        // Output is held low through acknowledge; a lone priority set raises nothing
        if (init_valid || capture || (ack_state != ACK_IDLE))
        begin
            next_int_request = 1'b0;
        end
        else if (cmd_valid && (cmd_code == CMD_SET_PRIORITY))
        begin
            next_int_request = int_request;
        end
        else
        begin
            next_int_request = raise;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            level_mask_bits      <= MASK_RESET;
            in_service_bits      <= SERVICE_RESET;
            special_mask_setting <= 1'b0;
            level_mode           <= LEVEL_MODE_RESET;
            auto_eos             <= AUTO_EOS_RESET;
            lowest_level         <= LOWEST_RESET;
            ack_state            <= ACK_IDLE;
            int_request          <= 1'b0;
            ack_level            <= LEVEL_SEVEN;
            ack_default          <= 1'b0;
            served_valid         <= 1'b0;
            served_level         <= LEVEL_SEVEN;
        end
        else
        begin
            level_mask_bits      <= next_level_mask_bits;
            in_service_bits      <= next_in_service_bits;
            special_mask_setting <= next_special_mask_setting;
            level_mode           <= next_level_mode;
            auto_eos             <= next_auto_eos;
            lowest_level         <= next_lowest_level;
            ack_state            <= next_ack_state;
            int_request          <= next_int_request;
            ack_level            <= next_ack_level;
            ack_default          <= next_ack_default;
            served_valid         <= next_served_valid;
            served_level         <= next_served_level;
        end
    end
endmodule : interrupt_mask_trigger_logic

// File: verification/irq_ctl_props.sv
// Port-level assertions for the interrupt mask and trigger logic
`timescale 1ns/100ps
module irq_ctl_props
    import irq_ctl_pkg::*;
(
    // Clock, reset and inputs
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic [7:0] bus_vectored_request_lines_n,
    input wire logic       init_valid,
    input wire logic       init_level_mode,
    input wire logic       init_auto_eos,
    input wire logic       mask_write,
    input wire logic [7:0] mask_data,
    input wire logic       cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic [2:0] cmd_level,
    input wire logic       acknowledge_pulse,
    // Outputs
    input wire logic       int_request,
    input wire logic [2:0] ack_level,
    input wire logic       ack_default,
    input wire logic [7:0] level_mask_bits,
    input wire logic [7:0] in_service_bits,
    input wire logic [7:0] request_latch_bits,
    input wire logic       special_mask_setting,
    input wire logic       level_mode,
    input wire logic [2:0] lowest_level
);
    logic [7:0] open_req;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Unmasked latch one edge back, since int_request comes from registered state
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            open_req <= 8'h00;
        else
            open_req <= request_latch_bits & ~level_mask_bits;
    end
    chk_mask_load: assert property (mask_write && !init_valid |=>
        level_mask_bits == $past(mask_data)) else $error("mask write not taken");
    chk_rot_clears: assert property (cmd_valid && cmd_code == CMD_SPEC_ROT && !init_valid
        && !acknowledge_pulse |=> !in_service_bits[$past(cmd_level)]
        && lowest_level == $past(cmd_level)) else $error("rotate and clear failed");
    chk_prio_set: assert property (cmd_valid && cmd_code == CMD_SET_PRIORITY
        && !init_valid |=> lowest_level == $past(cmd_level)) else $error("lowest level not set");
    chk_spmask_stays: assert property (special_mask_setting && !init_valid
        && !(cmd_valid && cmd_code == CMD_SPMASK_CLEAR) |=> special_mask_setting)
        else $error("special mask dropped");
    chk_int_cause: assert property ($rose(int_request) |-> open_req != 8'h00)
        else $error("interrupt without unmasked latch");
    chk_ack_answer: assert property ($rose(acknowledge_pulse) && int_request |=>
        !int_request && (ack_default ? ack_level == LEVEL_SEVEN : in_service_bits[ack_level]))
        else $error("acknowledge answer wrong");
    chk_spmask_nonspec: assert property (cmd_valid && cmd_code == CMD_NONSPEC_EOS
        && !init_valid && special_mask_setting && !mask_write && !acknowledge_pulse
        |=> (in_service_bits & level_mask_bits)
        == ($past(in_service_bits) & $past(level_mask_bits)))
        else $error("masked service bit cleared");
    chk_level_follow: assert property ((level_mode && !init_valid
        && $stable(bus_vectored_request_lines_n))[*4]
        |-> request_latch_bits == ~bus_vectored_request_lines_n) else $error("latch off line");
    chk_edge_steady: assert property ((!level_mode
        && $stable(bus_vectored_request_lines_n))[*5]
        |-> (request_latch_bits & ~$past(request_latch_bits)) == 8'h00)
        else $error("steady line set latch");
    chk_init_mode: assert property (init_valid |=> level_mode == $past(init_level_mode))
        else $error("trigger mode not loaded");
    cover property (cmd_valid && cmd_code == CMD_SPEC_ROT);
    cover property ($rose(acknowledge_pulse) && int_request);
    cover property (special_mask_setting && int_request);
endmodule : irq_ctl_props

// File: verification/host_cpu.sv
// Processor model: runs the two-pulse acknowledge sequence on request
`timescale 1ns/100ps
module host_cpu (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rstn,
    // Control from the bench
    input  wire logic ack_go,
    input  wire logic ack_slow,
    // Acknowledge side
    output logic      acknowledge_pulse,
    output logic      ack_done
);
    int hold;
    initial
    begin
        acknowledge_pulse = 1'b0;
        ack_done = 1'b0;
    end
    // Slow mode stretches every high and low phase to three cycles
    always @(negedge sys_clk)
    begin
        ack_done <= 1'b0;
        if (ack_go && rstn)
        begin
            hold = ack_slow ? 3 : 1;
            repeat (2)
            begin
                acknowledge_pulse <= 1'b1;
                repeat (hold) @(negedge sys_clk);
                acknowledge_pulse <= 1'b0;
                repeat (hold) @(negedge sys_clk);
            end
            ack_done <= 1'b1;
        end
    end
endmodule : host_cpu

// File: verification/test_interrupt_mask_trigger_logic.sv
// Self-checking bench for the interrupt mask and trigger logic
`timescale 1ns/100ps
module test_interrupt_mask_trigger_logic;
    import irq_ctl_pkg::*;
    logic       sys_clk = 1'b0, rstn = 1'b0, init_valid = 1'b0;
    logic       init_level_mode = 1'b0, init_auto_eos = 1'b0, mask_write = 1'b0;
    logic       cmd_valid = 1'b0, ack_go = 1'b0, ack_slow = 1'b0;
    logic [7:0] reqs = 8'h00, mask_data = 8'h00;
    logic [2:0] cmd_code = 3'h0;
    level_t     cmd_level = 3'h0;
    logic       acknowledge_pulse, ack_done, int_request, ack_default, special_mask_setting;
    logic       level_mode;
    level_t     ack_level, lowest_level;
    logic [7:0] level_mask_bits, in_service_bits, request_latch_bits;
    int         n_errors = 0, total_checks = 0, cycles = 0;

    interrupt_mask_trigger_logic uut (.sys_clk(sys_clk), .rstn(rstn),
        .bus_vectored_request_lines_n(~reqs), .init_valid(init_valid),
        .init_level_mode(init_level_mode), .init_auto_eos(init_auto_eos),
        .mask_write(mask_write), .mask_data(mask_data), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_level(cmd_level), .acknowledge_pulse(acknowledge_pulse),
        .int_request(int_request), .ack_level(ack_level), .ack_default(ack_default),
        .level_mask_bits(level_mask_bits), .in_service_bits(in_service_bits),
        .request_latch_bits(request_latch_bits), .special_mask_setting(special_mask_setting),
        .level_mode(level_mode), .lowest_level(lowest_level));
    host_cpu cpu (.sys_clk(sys_clk), .rstn(rstn), .ack_go(ack_go), .ack_slow(ack_slow),
        .acknowledge_pulse(acknowledge_pulse), .ack_done(ack_done));

    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wait_cyc

    task automatic set_mask(input logic [7:0] m);
        @(negedge sys_clk);
        mask_write = 1'b1;
        mask_data = m;
        @(negedge sys_clk);
        mask_write = 1'b0;
    endtask : set_mask

    task automatic send_cmd(input logic [2:0] code, input level_t lvl);
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_level = lvl;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        wait_cyc(2);
    endtask : send_cmd

    // Bounded wait so a stuck model cannot hang the run
    task automatic do_ack(input logic slow);
        int i;
        ack_slow = slow;
        @(negedge sys_clk);
        ack_go <= 1'b1;
        @(negedge sys_clk);
        ack_go <= 1'b0;
        for (i = 0; i < 40 && ack_done !== 1'b1; i++) @(negedge sys_clk);
        wait_cyc(3);
    endtask : do_ack

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            $display("FAIL timeout expected finish seen hang");
            report_and_stop();
        end
    end

    initial
    begin
        wait_cyc(8);
        rstn = 1'b1;
        wait_cyc(2);
        check("mask", 8'h00, level_mask_bits | in_service_bits | request_latch_bits);
        check("lowest", 8'h07, {5'h00, lowest_level});
        $display("test reset done");
        set_mask(8'h08);
        reqs[3] = 1'b1;
        wait_cyc(5);
        check("latch", 8'h08, request_latch_bits);
        check("int", 8'h00, {7'h00, int_request});
        set_mask(8'h00);
        wait_cyc(3);
        check("int", 8'h01, {7'h00, int_request});
        do_ack(1'b0);
        check("level", 8'h03, {5'h00, ack_level});
        wait_cyc(6);
        check("latch", 8'h00, request_latch_bits);
        reqs[3] = 1'b0;
        wait_cyc(4);
        reqs[3] = 1'b1;
        wait_cyc(5);
        check("latch", 8'h08, request_latch_bits);
        $display("test edge done");
        reqs[5] = 1'b1;
        wait_cyc(5);
        check("int", 8'h00, {7'h00, int_request});
        set_mask(8'h08);
        send_cmd(CMD_SPMASK_SET, 3'h0);
        check("int", 8'h01, {7'h00, int_request});
        do_ack(1'b1);
        check("service", 8'h28, in_service_bits);
        // Both in-service levels masked, a lower one still gets through
        set_mask(8'h28);
        reqs[6] = 1'b1;
        wait_cyc(5);
        check("int", 8'h01, {7'h00, int_request});
        reqs[6] = 1'b0;
        set_mask(8'h08);
        send_cmd(CMD_NONSPEC_EOS, 3'h0);
        check("service", 8'h08, in_service_bits);
        check("special", 8'h01, {7'h00, special_mask_setting});
        send_cmd(CMD_SPMASK_CLEAR, 3'h0);
        set_mask(8'h00);
        reqs = 8'h00;
        wait_cyc(5);
        send_cmd(CMD_SPEC_ROT, 3'h3);
        check("service", 8'h00, in_service_bits);
        check("lowest", 8'h03, {5'h00, lowest_level});
        send_cmd(CMD_SET_PRIORITY, 3'h6);
        check("int", 8'h00, {7'h00, int_request});
        reqs = 8'h81;
        wait_cyc(6);
        do_ack(1'b0);
        check("level", 8'h07, {4'h0, ack_default, ack_level});
        reqs = 8'h00;
        send_cmd(CMD_SPEC_EOS, 3'h7);
        // A stale level seven bit would win the rotation below
        reqs[4] = 1'b1;
        wait_cyc(6);
        do_ack(1'b0);
        send_cmd(CMD_NONSPEC_ROT, 3'h0);
        check("rotate", 8'h04, {in_service_bits[7:4], 1'b0, lowest_level});
        reqs[4] = 1'b0;
        $display("test priority done");
        reqs[2] = 1'b1;
        wait_cyc(6);
        reqs[2] = 1'b0;
        wait_cyc(4);
        do_ack(1'b0);
        check("default", 8'h0f, {4'h0, ack_default, ack_level});
        $display("test default done");
        @(negedge sys_clk);
        init_valid = 1'b1;
        init_level_mode = 1'b1;
        init_auto_eos = 1'b1;
        @(negedge sys_clk);
        init_valid = 1'b0;
        reqs[6] = 1'b1;
        wait_cyc(6);
        check("int", 8'h03, {6'h00, level_mode, int_request});
        do_ack(1'b1);
        check("service", 8'h00, in_service_bits);
        wait_cyc(2);
        check("int", 8'h01, {7'h00, int_request});
        reqs = 8'h00;
        wait_cyc(5);
        check("latch", 8'h00, request_latch_bits);
        $display("test level done");
        report_and_stop();
    end
endmodule : test_interrupt_mask_trigger_logic

bind interrupt_mask_trigger_logic irq_ctl_props chk (.sys_clk(sys_clk), .rstn(rstn),
    .bus_vectored_request_lines_n(bus_vectored_request_lines_n), .init_valid(init_valid),
    .init_level_mode(init_level_mode), .init_auto_eos(init_auto_eos),
    .mask_write(mask_write), .mask_data(mask_data), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_level(cmd_level), .acknowledge_pulse(acknowledge_pulse),
    .int_request(int_request), .ack_level(ack_level), .ack_default(ack_default),
    .level_mask_bits(level_mask_bits), .in_service_bits(in_service_bits),
    .request_latch_bits(request_latch_bits), .special_mask_setting(special_mask_setting),
    .level_mode(level_mode), .lowest_level(lowest_level));
